// [rtl/scan_sequencer.v]
// scan sequencer with time-stamped reading store and apb registers
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "scan_defs.vh"

module scan_sequencer (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [7:0]           paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output reg                  pready,
    output reg                  pslverr,
    input  wire                 key_pin,
    input  wire                 ext_trig_pin,
    input  wire                 ext_done_pin,
    input  wire                 alarm_event,
    input  wire                 meas_valid,
    input  wire [`DATA_W-1:0]   meas_data,
    output reg  [`CHAN_W-1:0]   chan_sel,
    output reg                  chan_closed,
    output reg                  chan_settled,
    output reg                  meas_start,
    output reg                  trig_wait,
    output reg                  irq
);

// one-hot states
localparam [4:0] S_IDLE   = 5'b00001;
localparam [4:0] S_ARM    = 5'b00010;
localparam [4:0] S_PICK   = 5'b00100;
localparam [4:0] S_SETTLE = 5'b01000;
localparam [4:0] S_MEAS   = 5'b10000;

reg  [4:0]              state;
reg  [`CTRL_W-1:0]      ctrl;
reg  [`INT_W-1:0]       int_stat;
reg  [`INT_W-1:0]       int_mask;
reg  [31:0]             interval;
reg  [31:0]             chan_dly;
reg  [`LIST_LW-1:0]     list_len;
reg  [`CHAN_W-1:0]      list [0:`LIST_DEPTH-1];
reg  [`MEM_W-1:0]       mem [0:`MEM_DEPTH-1];
reg  [`MEM_AW-1:0]      wr_ptr;
reg  [`MEM_AW-1:0]      rd_count;
reg  [`MEM_AW-1:0]      rd_index;
reg  [31:0]             ts;
reg  [31:0]             tick_cnt;
reg  [31:0]             dly_cnt;
reg  [`LIST_LW-1:0]     pos;
reg  [`LIST_IW-1:0]     cur;
reg  [`CHAN_W-1:0]      last_key;
reg                     first;
reg  [2:0]              pins_prev;
wire [2:0]              pins;

integer i;
integer j;  // reset loop only, so i has one driver

////////////////////////////////////////////////////////////////////////
// pins: key, external trigger, external done
pin_sync #(
    .W      (3)
) u_sync (
    .clk    (pclk),
    .rst_n  (presetn),
    .d      ({ext_done_pin, ext_trig_pin, key_pin}),
    .q      (pins)
);

wire [2:0] pin_rise = pins & ~pins_prev;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pins_prev <= 3'h0;
    end else begin
        pins_prev <= pins;
    end
end

////////////////////////////////////////////////////////////////////////
// apb decode; writes take effect at the completing edge
wire acc  = psel & penable & pready;
wire wr   = acc & pwrite;
wire is_list = (paddr[7:5] == `LIST_SEL);
wire [`LIST_IW-1:0] list_wi = paddr[4:2];

wire cmd_wr    = wr & (paddr == `A_CMD);
wire start_cmd = cmd_wr & pwdata[`CMD_START];
wire stop_cmd  = cmd_wr & pwdata[`CMD_STOP];
wire soft_trig = cmd_wr & pwdata[`CMD_TRIG];

wire nonseq = ctrl[`CTRL_NONSEQ];
wire ext_m  = ctrl[`CTRL_EXT];
wire [2:0] src = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];

////////////////////////////////////////////////////////////////////////
// interval timer, runs only while a scan is armed or sweeping
wire scanning = ~state[0];
wire tick = scanning & (interval != 32'h0) &
            (tick_cnt == interval - 32'h1);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tick_cnt <= 32'h0;
    end else if (!scanning || tick || start_cmd) begin
        tick_cnt <= 32'h0;
    end else begin
        tick_cnt <= tick_cnt + 32'h1;
    end
end

////////////////////////////////////////////////////////////////////////
// sweep start source select
reg sweep_go;

always @* begin
    case (src)
        `SRC_TIMER: sweep_go = tick;
        `SRC_KEY:   sweep_go = pin_rise[0];
        `SRC_SOFT:  sweep_go = soft_trig;
        `SRC_EXT:   sweep_go = pin_rise[1];
        `SRC_ALARM: sweep_go = alarm_event;
        default:    sweep_go = 1'b0;
    endcase
end

////////////////////////////////////////////////////////////////////////
// next channel search; sequential mode takes the smallest key above
// the last one, so the list need not be sorted by software
reg                 found;
reg [`LIST_IW-1:0]  pick;

always @* begin
    found = 1'b0;
    pick  = {`LIST_IW{1'b0}};
    if (nonseq) begin
        found = (pos < list_len);
        pick  = pos[`LIST_IW-1:0];
    end else begin
        for (i = 0; i < `LIST_DEPTH; i = i + 1) begin
            if ((i < list_len) && (first || list[i] > last_key) &&
                (!found || list[i] < list[pick])) begin
                found = 1'b1;
                pick  = i[`LIST_IW-1:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// measurement done: external pin or internal meter
wire meas_done = ext_m ? pin_rise[2] : meas_valid;
wire store = state[4] & meas_done & ~ext_m;
wire full  = (rd_count == `MEM_DEPTH);

////////////////////////////////////////////////////////////////////////
// sequencer state machine
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state        <= S_IDLE;
        pos          <= {`LIST_LW{1'b0}};
        cur          <= {`LIST_IW{1'b0}};
        last_key     <= {`CHAN_W{1'b0}};
        first        <= 1'b1;
        dly_cnt      <= 32'h0;
        chan_sel     <= {`CHAN_W{1'b0}};
        chan_closed  <= 1'b0;
        chan_settled <= 1'b0;
        meas_start   <= 1'b0;
        trig_wait    <= 1'b0;
    end else begin
        chan_settled <= 1'b0;
        meas_start   <= 1'b0;
        if (stop_cmd) begin
            state       <= S_IDLE;
            chan_closed <= 1'b0;
            trig_wait   <= 1'b0;
        end else if (start_cmd) begin
            // a new scan abandons any sweep in progress
            state       <= S_ARM;
            chan_closed <= 1'b0;
            trig_wait   <= 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    trig_wait <= 1'b0;
                end
                S_ARM: begin
                    if (sweep_go && list_len != 4'h0) begin
                        state     <= S_PICK;
                        trig_wait <= 1'b0;
                        pos       <= {`LIST_LW{1'b0}};
                        first     <= 1'b1;
                    end
                end
                S_PICK: begin
                    if (found) begin
                        // only one relay closed at any moment
                        chan_sel    <= list[pick];
                        chan_closed <= 1'b1;
                        cur         <= pick;
                        last_key    <= list[pick];
                        first       <= 1'b0;
                        pos         <= pos + 4'h1;
                        dly_cnt     <= 32'h0;
                        state       <= S_SETTLE;
                    end else begin
                        state     <= S_ARM;
                        trig_wait <= 1'b1;
                    end
                end
                S_SETTLE: begin
                    if (dly_cnt >= chan_dly) begin
                        chan_settled <= ext_m;
                        meas_start   <= ~ext_m;
                        state        <= S_MEAS;
                    end else begin
                        dly_cnt <= dly_cnt + 32'h1;
                    end
                end
                S_MEAS: begin
                    if (meas_done) begin
                        chan_closed <= 1'b0;
                        state       <= S_PICK;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////
// reading store pointers; a new scan empties it
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wr_ptr   <= {`MEM_AW{1'b0}};
        rd_count <= {`MEM_AW{1'b0}};
        ts       <= 32'h0;
    end else if (start_cmd) begin
        wr_ptr   <= {`MEM_AW{1'b0}};
        rd_count <= {`MEM_AW{1'b0}};
        ts       <= 32'h0;
    end else begin
        ts <= ts + 32'h1;
        if (store) begin
            // circular write keeps the newest readings
            if (wr_ptr == `MEM_DEPTH - 19'd1) begin
                wr_ptr <= {`MEM_AW{1'b0}};
            end else begin
                wr_ptr <= wr_ptr + 19'd1;
            end
            if (!full) begin
                rd_count <= rd_count + 19'd1;
            end
        end
    end
end

// storage needs no reset; the count says what is valid
always @(posedge pclk) begin
    if (store) begin
        mem[wr_ptr] <= {ts, list[cur], meas_data};
    end
end

////////////////////////////////////////////////////////////////////////
// read address: oldest reading is index zero
reg [19:0] base;
reg [19:0] raddr;

always @* begin
    if (wr_ptr >= rd_count) begin
        base = {1'b0, wr_ptr - rd_count};
    end else begin
        base = {1'b0, wr_ptr} + `MEM_DEPTH20 - {1'b0, rd_count};
    end
    raddr = base + {1'b0, rd_index};
    if (raddr >= `MEM_DEPTH20) begin
        raddr = raddr - `MEM_DEPTH20;
    end
end

wire          rd_ok  = (rd_index < rd_count);
wire [`MEM_W-1:0] rword = rd_ok ? mem[raddr[`MEM_AW-1:0]] :
                                  {`MEM_W{1'b0}};

////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl     <= `CTRL_RST;
        int_mask <= `INT_RST;
        interval <= `TIME_RST;
        chan_dly <= `TIME_RST;
        list_len <= {`LIST_LW{1'b0}};
        rd_index <= {`MEM_AW{1'b0}};
        for (j = 0; j < `LIST_DEPTH; j = j + 1) begin
            list[j] <= {`CHAN_W{1'b0}};
        end
    end else if (wr) begin
        case (paddr)
            `A_CTRL:     ctrl     <= pwdata[`CTRL_W-1:0];
            `A_INT_MASK: int_mask <= pwdata[`INT_W-1:0];
            `A_INTERVAL: interval <= pwdata;
            `A_CHAN_DLY: chan_dly <= pwdata;
            `A_LIST_LEN: begin
                // longer than the list is clipped to its depth
                if (pwdata[31:4] != 28'h0 || pwdata[3]) begin
                    list_len <= 4'h8;
                end else begin
                    list_len <= pwdata[3:0];
                end
            end
            `A_RD_INDEX: rd_index <= pwdata[`MEM_AW-1:0];
            default: begin
                if (is_list) begin
                    list[list_wi] <= pwdata[`CHAN_W-1:0];
                end
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// interrupt status: set wins over a write-one clear
wire [`INT_W-1:0] int_set;
wire [`INT_W-1:0] int_clr;

assign int_set = {store & full, store, state[2] & ~found};
assign int_clr = (wr && paddr == `A_INT_STAT) ?
                 pwdata[`INT_W-1:0] : {`INT_W{1'b0}};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        int_stat <= `INT_RST;
        irq      <= 1'b0;
    end else begin
        int_stat <= (int_stat & ~int_clr) | int_set;
        irq      <= |(((int_stat & ~int_clr) | int_set) & int_mask);
    end
end

////////////////////////////////////////////////////////////////////////
// read mux; a read of the store changes no state
reg [31:0] rmux;
reg        rerr;

always @* begin
    rmux = 32'h0;
    rerr = 1'b0;
    case (paddr)
        `A_CTRL:     rmux = {25'h0, ctrl};
        `A_CMD:      rmux = 32'h0;
        `A_STATUS:   rmux = {21'h0, cur, 3'h0, state};
        `A_INT_STAT: rmux = {29'h0, int_stat};
        `A_INT_MASK: rmux = {29'h0, int_mask};
        `A_INTERVAL: rmux = interval;
        `A_CHAN_DLY: rmux = chan_dly;
        `A_LIST_LEN: rmux = {28'h0, list_len};
        `A_RD_COUNT: rmux = {13'h0, rd_count};
        `A_RD_INDEX: rmux = {13'h0, rd_index};
        `A_RD_DATA:  rmux = {8'h0, rword[23:0]};
        `A_RD_CHAN:  rmux = {15'h0, rword[40:24]};
        `A_RD_TIME:  rmux = rword[72:41];
        default: begin
            if (is_list) begin
                rmux = {15'h0, list[list_wi]};
            end else begin
                rerr = 1'b1;
            end
        end
    endcase
end

////////////////////////////////////////////////////////////////////////
// apb answer: one wait-free access phase after each setup
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= psel & ~penable & rerr;
        if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rmux;
        end
    end
end

endmodule // scan_sequencer

// [common/scan_defs.vh]
// constants for the scan sequencer: offsets, fields, reset values, sizes
`ifndef SCAN_DEFS_VH
`define SCAN_DEFS_VH

// register byte addresses
`define A_CTRL      8'h00
`define A_CMD       8'h04
`define A_STATUS    8'h08
`define A_INT_STAT  8'h0c
`define A_INT_MASK  8'h10
`define A_INTERVAL  8'h14
`define A_CHAN_DLY  8'h18
`define A_LIST_LEN  8'h1c
`define A_RD_COUNT  8'h20
`define A_RD_INDEX  8'h24
`define A_RD_DATA   8'h28
`define A_RD_CHAN   8'h2c
`define A_RD_TIME   8'h30
// scan list window 0x40..0x5c, one entry per word
`define LIST_SEL    3'h2
`define LIST_DEPTH  8
`define LIST_IW     3
`define LIST_LW     4

// control register fields
`define CTRL_NONSEQ 0
`define CTRL_EXT    1
`define CTRL_SRC_LO 4
`define CTRL_SRC_HI 6
`define CTRL_W      7
`define CTRL_RST    7'h00

// command register bits (write-only pulses)
`define CMD_START   0
`define CMD_STOP    1
`define CMD_TRIG    2

// sweep start sources
`define SRC_TIMER   3'h0
`define SRC_KEY     3'h1
`define SRC_SOFT    3'h2
`define SRC_EXT     3'h3
`define SRC_ALARM   3'h4

// interrupt status / mask bits
`define INT_SWEEP   0
`define INT_READ    1
`define INT_OVWR    2
`define INT_W       3
`define INT_RST     3'h0

// timing registers reset to zero: no interval ticks, no delay
`define TIME_RST    32'h0000_0000

// list entry: [15:0] channel number, [16] digital channel flag
`define CHAN_W      17

// reading store
`define MEM_DEPTH   19'd500000
`define MEM_DEPTH20 20'd500000
`define MEM_AW      19
`define DATA_W      24
`define TS_W        32
`define MEM_W       73

`endif

// [rtl/pin_sync.v]
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/100ps

module pin_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

reg [W-1:0] meta;

////////////////////////////////////////////////////////////////////////
// first stage is read only by the second stage
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        meta <= {W{1'b0}};
        q    <= {W{1'b0}};
    end else begin
        meta <= d;
        q    <= meta;
    end
end

endmodule // pin_sync

// [tb/scan_monitor.sv]
// port checker for the scan sequencer
`timescale 1ns/100ps
`include "scan_defs.vh"

module scan_monitor (
    input wire               pclk,
    input wire               presetn,
    input wire               psel,
    input wire               penable,
    input wire               pwrite,
    input wire [7:0]         paddr,
    input wire [31:0]        pwdata,
    input wire               pready,
    input wire               pslverr,
    input wire [`CHAN_W-1:0] chan_sel,
    input wire               chan_closed,
    input wire               chan_settled,
    input wire               meas_start,
    input wire               trig_wait
);
    reg [31:0] dly;
    reg [31:0] held;

    ////////////////////////////////////////////////////////////////////////
    // shadow of the settle delay; only valid if not rewritten mid-settle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly  <= 32'h0;
            held <= 32'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == `A_CHAN_DLY)
                dly <= pwdata;
            held <= chan_closed ? held + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    a_settle_count: assert property (
        (meas_start || chan_settled) |-> held == dly + 32'h1)
        else $error("settle pulse off the programmed delay");
    a_meas_closed: assert property (
        meas_start |-> chan_closed && !trig_wait)
        else $error("measure outside a running sweep");
    a_pulse_single: assert property (
        (meas_start || chan_settled) |=> !meas_start && !chan_settled)
        else $error("settle pulse longer than one cycle");
    a_mode_excl: assert property (
        !(meas_start && chan_settled))
        else $error("both meter pulses at once");
    a_sel_stable: assert property (
        chan_closed ##1 chan_closed |-> $stable(chan_sel))
        else $error("channel changed while closed");
    a_open_gap: assert property (
        $changed(chan_sel) |-> !$past(chan_closed))
        else $error("channel moved while a relay was closed");
    a_ext_hold: assert property (
        chan_settled |=> chan_closed [*3])
        else $error("advanced before meter done");
    a_armed_open: assert property (
        trig_wait |-> !chan_closed)
        else $error("channel closed while armed");
    a_ready_next: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_err_hole: assert property (
        pready && paddr == 8'h38 |-> pslverr)
        else $error("unmapped address without error");
endmodule // scan_monitor

bind scan_sequencer scan_monitor mon_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .chan_sel(chan_sel), .chan_closed(chan_closed),
    .chan_settled(chan_settled), .meas_start(meas_start),
    .trig_wait(trig_wait)
);

// [tb/meter_model.sv]
// model of the meter on the trigger lines, internal or external
`timescale 1ns/100ps

module meter_model (
    input wire        pclk,
    input wire        presetn,
    input wire        meas_start,
    input wire        chan_settled,
    input wire [16:0] chan_sel,
    input wire [3:0]  lat,
    output reg        meas_valid,
    output reg [23:0] meas_data,
    output reg        ext_done_pin
);
    reg [3:0] cnt;
    reg [2:0] hold;
    reg       busy;
    reg       ext;

    ////////////////////////////////////////////////////////////////////////
    // answer each request lat+1 cycles after it; data inverted once released
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {meas_valid, ext_done_pin, busy, ext} <= 4'h0;
            {meas_data, cnt, hold} <= 31'h0;
        end else begin
            meas_valid <= 1'b0;
            if (meas_valid)
                meas_data <= ~meas_data;
            if (hold != 3'h0)
                hold <= hold - 3'h1;
            else
                ext_done_pin <= 1'b0;
            if (meas_start || chan_settled) begin
                busy <= 1'b1;
                cnt  <= lat;
                ext  <= chan_settled;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                // short done pulse so the next channel sees a fresh rise
                if (ext) begin
                    ext_done_pin <= 1'b1;
                    hold         <= 3'h2;
                end else begin
                    meas_valid <= 1'b1;
                    meas_data  <= {8'ha5, chan_sel[15:0]};
                end
            end
        end
    end
endmodule // meter_model

// [tb/tb_scan_sequencer.sv]
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`include "scan_defs.vh"

module tb_scan_sequencer;
    reg          pclk = 1'b0;
    reg          presetn = 1'b0;
    reg          psel = 1'b0;
    reg          penable = 1'b0;
    reg          pwrite = 1'b0;
    reg  [7:0]   paddr = 8'h0;
    reg  [31:0]  pwdata = 32'h0;
    reg          key_pin = 1'b0;
    reg          ext_trig_pin = 1'b0;
    reg          alarm_event = 1'b0;
    reg  [3:0]   lat = 4'h1;
    reg          prev_closed = 1'b0;
    wire [31:0]  prdata;
    wire         pready, pslverr, ext_done_pin, meas_valid;
    wire [23:0]  meas_data;
    wire [16:0]  chan_sel;
    wire         chan_closed, chan_settled, meas_start, trig_wait, irq;
    integer      bad_count = 0;
    integer      total_checks = 0;
    integer      seed_val, i;
    reg  [32:0]  rdq[$];
    reg  [16:0]  chq[$];
    reg  [16:0]  ent[0:2];

    scan_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_pin(key_pin), .ext_trig_pin(ext_trig_pin),
        .ext_done_pin(ext_done_pin), .alarm_event(alarm_event),
        .meas_valid(meas_valid), .meas_data(meas_data),
        .chan_sel(chan_sel), .chan_closed(chan_closed),
        .chan_settled(chan_settled), .meas_start(meas_start),
        .trig_wait(trig_wait), .irq(irq));
    meter_model meter_u (.pclk(pclk), .presetn(presetn),
        .meas_start(meas_start), .chan_settled(chan_settled),
        .chan_sel(chan_sel), .lat(lat), .meas_valid(meas_valid),
        .meas_data(meas_data), .ext_done_pin(ext_done_pin));

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////
    task check(input ok);
        begin
            total_checks++;
            if (!ok) begin
                bad_count++;
                $display("BAD %0t mismatch", $time);
            end
        end
    endtask

    task close_out;
        begin
            if (bad_count == 0 && total_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // one apb transfer; an idle edge always precedes the setup cycle
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50) begin
                n++;
                @(posedge pclk);
            end
            {psel, penable} <= 2'b00;
            // a slave that never answers must not pass silently
            if (n >= 50)
                check(1'b0);
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input [7:0] a, input [32:0] e);
        begin
            rdq.push_back(e);
            apb(1'b0, a, 32'h0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watcher: oldest note against each read and each channel closure
    always @(posedge pclk) begin
        prev_closed <= chan_closed;
        if (psel && penable && pready && !pwrite) begin
            check(rdq.size() != 0 && {pslverr, prdata} === rdq[0]);
            if (rdq.size() != 0)
                rdq.delete(0);
        end
        if (chan_closed === 1'b1 && prev_closed !== 1'b1) begin
            check(chq.size() != 0 && chan_sel === chq[0]);
            if (chq.size() != 0)
                chq.delete(0);
        end
    end

    // key and external pins held 4 cycles so the synchroniser sees them
    task fire(input [2:0] s);
        begin
            if (s == `SRC_SOFT)
                wr(`A_CMD, 32'h4);
            @(posedge pclk);
            key_pin      <= (s == `SRC_KEY);
            ext_trig_pin <= (s == `SRC_EXT);
            alarm_event  <= (s == `SRC_ALARM);
            @(posedge pclk);
            alarm_event <= 1'b0;
            repeat (3) @(posedge pclk);
            {key_pin, ext_trig_pin} <= 2'b00;
        end
    endtask

    task sweep(input [2:0] s, input ns, input ex);
        integer k, n;
        reg [16:0] v[0:2];
        begin
            lat <= 4'($urandom % 6 + 1);
            wr(`A_CTRL, {25'h0, s, 2'b00, ex, ns});
            wr(`A_INTERVAL, s == `SRC_TIMER ? 32'd200 : 32'd0);
            wr(`A_CMD, 32'h1);
            for (k = 0; k < 3; k++) begin
                v[k] = ent[ns ? k : (k == 0 ? 1 : (k == 1 ? 0 : 2))];
                chq.push_back(v[k]);
            end
            fire(s);
            n = 0;
            while (irq !== 1'b1 && n < 3000) begin
                @(posedge pclk);
                n++;
            end
            check(n < 3000);
            wr(`A_CMD, 32'h2);
            for (k = 0; k < 3 && !ex; k++) begin
                wr(`A_RD_INDEX, k);
                rd(`A_RD_CHAN, {16'h0, v[k]});
                rd(`A_RD_DATA, {9'h0, 8'ha5, v[k][15:0]});
            end
            rd(`A_RD_COUNT, ex ? 33'd0 : 33'd3);
            wr(`A_INT_STAT, 32'h1);
            rd(`A_INT_STAT, ex ? 33'd0 : 33'd2);
            check(irq === 1'b0);
            wr(`A_INT_STAT, 32'h2);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed_val = $urandom(32'hd7ff);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(`A_CTRL, 33'h0);
        for (i = 0; i < 4; i++)
            rd(8'(`A_INT_MASK + 4 * i), 33'h0);
        rd(8'h38, {1'b1, 32'h0});
        ent[0] = {5'h02, 12'($urandom)};
        ent[1] = {5'h01, 12'($urandom)};
        ent[2] = {5'h10, 12'($urandom)};
        for (i = 0; i < 3; i++)
            wr(8'(8'h40 + 4 * i), {15'h0, ent[i]});
        wr(8'h4c, 32'h5);
        wr(`A_LIST_LEN, 32'd3);
        wr(`A_CHAN_DLY, $urandom % 4);
        wr(`A_INT_MASK, 32'h1);
        sweep(`SRC_SOFT, 1'b0, 1'b0);
        sweep(`SRC_TIMER, 1'b1, 1'b0);
        sweep(`SRC_KEY, 1'b0, 1'b0);
        sweep(`SRC_EXT, 1'b1, 1'b0);
        sweep(`SRC_ALARM, 1'b0, 1'b1);
        check(chq.size() == 0);
        close_out;
    end

    // watchdog well beyond the several hundred cycles the sweeps need
    initial begin
        #500000;
        bad_count++;
        close_out;
    end
endmodule // tb_scan_sequencer
